/* File: include/cle_pkg.sv */
// Shared constants for the link error counter block
package cle_pkg;
    // Link count and widths
    localparam int LINK_MAX = 4;
    localparam int SEL_W = 2;
    localparam int VIOL_W = 12;
    localparam int TAG_W_DEF = 8;
    localparam int WB_ADR_W = 8;
    // Heartbeat period limit, derived cycle count
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int HB_MAX_PERIOD_MS = 100;
    localparam int HB_TIMEOUT_CYC = CLK_FREQ_HZ / 1000 * HB_MAX_PERIOD_MS;
    // Register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TAG_MISMATCH = 8'h04;
    localparam logic [7:0] ADR_ACK_MALFORMED = 8'h08;
    localparam logic [7:0] ADR_HB_PARTIAL = 8'h0C;
    localparam logic [7:0] ADR_HB_LATE = 8'h10;
    localparam logic [7:0] ADR_LOST_PKT = 8'h14;
    localparam logic [7:0] ADR_REORDER_OVR = 8'h18;
    localparam logic [7:0] ADR_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADR_LINK_STATUS = 8'h24;
    // Control register fields and reset values
    localparam int CTRL_HB_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 4;
    localparam logic CTRL_HB_EN_RST = 1'b1;
    localparam logic [1:0] CTRL_SEL_RST = 2'h0;
    // Event bit positions in status and mask
    localparam int EV_TAG = 0;
    localparam int EV_MALF = 1;
    localparam int EV_HB_PART = 2;
    localparam int EV_HB_LATE = 3;
    localparam int EV_LOST = 4;
    localparam int EV_OVR = 5;
    localparam int EV_N = 6;
    localparam logic [EV_N-1:0] IRQ_MASK_RST = 6'h00;
    // Per-link counter kinds
    localparam int KIND_N = 4;
endpackage

/* File: include/cle_cnt_if.sv */
// Increment request and count value between block and one counter
`timescale 1ns/10ps
interface cle_cnt_if #(
    parameter int W = 12
);
    logic inc; // One-cycle increment strobe
    logic [W-1:0] amt; // Amount added on a strobe
    logic [W:0] value; // Overflow flag above the count
    modport src (output inc, output amt, input value);
    modport cnt (input inc, input amt, output value);
endinterface

/* File: hdl/cle_err_counter.sv */
// One error counter: sticky overflow flag or saturating form
`timescale 1ns/10ps
module cle_err_counter #(
    parameter int W = 12,
    parameter bit STICKY = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Increment side
    cle_cnt_if.cnt cnt_if
);
    logic [W-1:0] count_reg; // Running count
    logic flag_reg; // Overflow seen since reset
    logic [W:0] sum_w; // Count plus amount, carry on top

    if (W < 1) begin : g_chk
        $error("cle_err_counter: W must be at least 1");
    end

    assign sum_w = {1'b0, count_reg} + {1'b0, cnt_if.amt};
    assign cnt_if.value = {flag_reg, count_reg};

    // Count update; sticky kind wraps and flags, other kind holds at max
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_reg <= '0;
            flag_reg <= 1'b0;
        end else if (cnt_if.inc) begin
            if (STICKY) begin
                count_reg <= sum_w[W-1:0];
                if (sum_w[W]) begin
                    flag_reg <= 1'b1;
                end
            end else if (sum_w[W]) begin
                count_reg <= '1;
            end else begin
                count_reg <= sum_w[W-1:0];
            end
        end
    end
endmodule

/* File: hdl/cle_link_errors.sv */
// Per-link control, heartbeat and stream error statistics
`timescale 1ns/10ps
// Functional notes
// - Count well-formed acks whose tag differs from request
// - Violation count sits in bits 11..0
// - Bit 12 sets on count overflow
// - Count wrongly formatted control acks
// - Ack missing end-of-packet counts as malformed
// - Count heartbeats missing end-of-packet
// - Count heartbeat gaps longer than 100 ms
// - Count lost stream packets, range 0..4095
// - Count reorder buffer overruns, range 0..4095
module cle_link_errors #(
    parameter int LINKS = cle_pkg::LINK_MAX,
    parameter int TAG_W = cle_pkg::TAG_W_DEF,
    parameter int HB_TIMEOUT_CYCLES = cle_pkg::HB_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cle_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Outgoing control requests, per link
    input wire logic [LINKS-1:0] req_sent_i,
    input wire logic [LINKS*TAG_W-1:0] req_tag_i,
    // Received control acks, per link
    input wire logic [LINKS-1:0] ack_valid_i,
    input wire logic [LINKS-1:0] ack_eop_i,
    input wire logic [LINKS*TAG_W-1:0] ack_tag_i,
    // Received heartbeats, per link
    input wire logic [LINKS-1:0] hb_valid_i,
    input wire logic [LINKS-1:0] hb_eop_i,
    // Stream packet tags and reorder buffer
    input wire logic stream_pkt_valid_i,
    input wire logic [TAG_W-1:0] stream_pkt_tag_i,
    input wire logic pbuf_overflow_i,
    // Interrupt
    output logic irq_o
);
    localparam int VW = cle_pkg::VIOL_W;
    localparam int TMR_W = $clog2(HB_TIMEOUT_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(HB_TIMEOUT_CYCLES - 1);
    // Timer is wide enough to reach the limit without wrapping

    // Refuse shapes the logic cannot serve
    if (LINKS < 1 || LINKS > cle_pkg::LINK_MAX) begin : g_chk_links
        $error("cle_link_errors: LINKS must be 1 to 4");
    end
    if (TAG_W < 1 || TAG_W > VW) begin : g_chk_tag
        $error("cle_link_errors: TAG_W must be 1 to 12");
    end
    if (HB_TIMEOUT_CYCLES < 2) begin : g_chk_tmo
        $error("cle_link_errors: HB_TIMEOUT_CYCLES below 2");
    end
    if ((1 << cle_pkg::SEL_W) < LINKS) begin : g_chk_sel
        $error("cle_link_errors: select field too narrow");
    end

    // Control register state
    logic hb_en_reg; // Heartbeat gap monitor on
    logic [cle_pkg::SEL_W-1:0] link_index_select; // Read copy picker
    logic [cle_pkg::EV_N-1:0] irq_status_reg; // Sticky event bits
    logic [cle_pkg::EV_N-1:0] irq_status_next;
    logic [cle_pkg::EV_N-1:0] irq_mask_reg; // Interrupt enables

    // Bus handshake state
    logic wb_ack_reg;
    logic wb_err_reg;
    logic [31:0] wb_dat_reg;

    // Per-link tracking state
    logic [TAG_W-1:0] exp_tag_reg [LINKS]; // Last request tag
    logic [TMR_W-1:0] hb_tmr_reg [LINKS]; // Cycles since heartbeat
    logic [LINKS-1:0] hb_late_reg; // Gap already counted

    // Per-link event strobes, one bit per link
    logic [LINKS-1:0] tag_ev_w;
    logic [LINKS-1:0] malf_ev_w;
    logic [LINKS-1:0] hbp_ev_w;
    logic [LINKS-1:0] late_ev_w;

    // Stream tag tracking
    logic [TAG_W-1:0] next_tag_reg; // Tag the next packet should carry
    logic tag_seen_reg; // A first packet has set the baseline
    logic [TAG_W-1:0] tag_gap_w; // Packets skipped by this one
    logic lost_ev_w;

    // Counter value views for the read mux
    logic [VW:0] link_val_w [cle_pkg::KIND_N][LINKS];
    logic [VW:0] lost_val_w;
    logic [VW:0] ovr_val_w;

    // Counter carriers: kind k of link l sits at k*LINKS+l
    cle_cnt_if #(.W(VW)) lk_if [cle_pkg::KIND_N*LINKS] ();
    cle_cnt_if #(.W(VW)) lost_if ();
    cle_cnt_if #(.W(VW)) ovr_if ();

    // Loop indices for links and counter kinds
    genvar gl;
    genvar gk;

    // Per-link event detection
    for (gl = 0; gl < LINKS; gl++) begin : g_link
        logic [TAG_W-1:0] req_tag_w;
        logic [TAG_W-1:0] ack_tag_w;
        logic tmr_stop_w;
        assign req_tag_w = req_tag_i[gl*TAG_W +: TAG_W];
        assign ack_tag_w = ack_tag_i[gl*TAG_W +: TAG_W];

        // Request and ack in one cycle: the ack meets the older tag,
        // since the new one lands only at that edge
        // Only well-formed acks have a tag worth comparing
        assign tag_ev_w[gl] = ack_valid_i[gl] & ack_eop_i[gl]
                            & (ack_tag_w != exp_tag_reg[gl]);
        assign malf_ev_w[gl] = ack_valid_i[gl] & ~ack_eop_i[gl];
        assign hbp_ev_w[gl] = hb_valid_i[gl] & ~hb_eop_i[gl];

        // Gap over the limit, counted once per silent stretch
        assign tmr_stop_w = hb_late_reg[gl] | ~hb_en_reg;
        assign late_ev_w[gl] = ~hb_valid_i[gl] & ~tmr_stop_w
                             & (hb_tmr_reg[gl] == TMR_LAST);

        // Remember the tag of the latest outgoing request
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                exp_tag_reg[gl] <= '0;
            end else if (req_sent_i[gl]) begin
                exp_tag_reg[gl] <= req_tag_w;
            end
        end

        // Timer parks at the limit instead of wrapping, so a dead
        // link is reported once, not once every limit period
        // Heartbeat gap timer; any heartbeat, whole or not, restarts it
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                hb_tmr_reg[gl] <= '0;
                hb_late_reg[gl] <= 1'b0;
            end else if (hb_valid_i[gl] || !hb_en_reg) begin
                hb_tmr_reg[gl] <= '0;
                hb_late_reg[gl] <= 1'b0;
            end else if (late_ev_w[gl]) begin
                hb_late_reg[gl] <= 1'b1;
            end else if (!tmr_stop_w) begin
                hb_tmr_reg[gl] <= hb_tmr_reg[gl] + TMR_W'(1);
            end
        end

        // Feed the four per-link counters
        assign lk_if[0*LINKS+gl].inc = tag_ev_w[gl];
        assign lk_if[1*LINKS+gl].inc = malf_ev_w[gl];
        assign lk_if[2*LINKS+gl].inc = hbp_ev_w[gl];
        assign lk_if[3*LINKS+gl].inc = late_ev_w[gl];
        for (gk = 0; gk < cle_pkg::KIND_N; gk++) begin : g_kind
            assign lk_if[gk*LINKS+gl].amt = VW'(1);
            assign link_val_w[gk][gl] = lk_if[gk*LINKS+gl].value;
        end
    end

    // One counter copy per link and kind
    for (gl = 0; gl < cle_pkg::KIND_N * LINKS; gl++) begin : g_cnt
        cle_err_counter #(
            .W(VW),
            .STICKY(1'b1)
        ) u_cnt (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .cnt_if(lk_if[gl])
        );
    end

    // A stale reordered tag looks like a huge gap and inflates the
    // lost count; the reorder buffer owns that case, not this logic
    // Stream tag discontinuity: skipped tags are lost packets
    assign tag_gap_w = stream_pkt_tag_i - next_tag_reg;
    assign lost_ev_w = stream_pkt_valid_i & tag_seen_reg
                     & (tag_gap_w != '0);

    // Track the tag the next packet should carry
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            next_tag_reg <= '0;
            tag_seen_reg <= 1'b0;
        end else if (stream_pkt_valid_i) begin
            next_tag_reg <= stream_pkt_tag_i + TAG_W'(1);
            tag_seen_reg <= 1'b1;
        end
    end

    // Stream counters hold at 4095 instead of flagging
    assign lost_if.inc = lost_ev_w;
    assign lost_if.amt = VW'(tag_gap_w);
    assign lost_val_w = lost_if.value;
    assign ovr_if.inc = pbuf_overflow_i;
    assign ovr_if.amt = VW'(1);
    assign ovr_val_w = ovr_if.value;

    cle_err_counter #(
        .W(VW),
        .STICKY(1'b0)
    ) u_lost (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .cnt_if(lost_if)
    );

    cle_err_counter #(
        .W(VW),
        .STICKY(1'b0)
    ) u_ovr (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .cnt_if(ovr_if)
    );

    // Bus decode
    logic wb_req_w; // New request not yet answered
    logic wb_wr_w;
    logic hit_ctrl_w;
    logic hit_cnt_w;
    logic hit_stat_w;
    logic hit_mask_w;
    logic hit_any_w;
    logic sel_ok_w; // Selected copy exists
    logic [cle_pkg::SEL_W-1:0] sel_w;
    logic [31:0] ctrl_rd_w;
    logic [31:0] rd_data_w;

    assign wb_req_w = wb_cyc_i & wb_stb_i & ~wb_ack_reg & ~wb_err_reg;
    assign wb_wr_w = wb_req_w & wb_we_i & hit_any_w;
    assign hit_ctrl_w = (wb_adr_i == cle_pkg::ADR_CTRL);
    assign hit_stat_w = (wb_adr_i == cle_pkg::ADR_IRQ_STATUS);
    assign hit_mask_w = (wb_adr_i == cle_pkg::ADR_IRQ_MASK);
    // Counter addresses are read-only; writes are acked and dropped
    assign hit_cnt_w = (wb_adr_i == cle_pkg::ADR_TAG_MISMATCH)
                     | (wb_adr_i == cle_pkg::ADR_ACK_MALFORMED)
                     | (wb_adr_i == cle_pkg::ADR_HB_PARTIAL)
                     | (wb_adr_i == cle_pkg::ADR_HB_LATE)
                     | (wb_adr_i == cle_pkg::ADR_LOST_PKT)
                     | (wb_adr_i == cle_pkg::ADR_REORDER_OVR)
                     | (wb_adr_i == cle_pkg::ADR_LINK_STATUS);
    assign hit_any_w = hit_ctrl_w | hit_cnt_w | hit_stat_w | hit_mask_w;

    // Copy picker; a missing copy reads as zero
    assign sel_w = link_index_select;
    assign sel_ok_w = (32'(sel_w) < LINKS);

    assign ctrl_rd_w = {26'h0, link_index_select, 3'h0, hb_en_reg};

    // Read selection
    assign rd_data_w =
        hit_ctrl_w ? ctrl_rd_w :
        (wb_adr_i == cle_pkg::ADR_TAG_MISMATCH && sel_ok_w) ?
            32'(link_val_w[0][sel_w]) :
        (wb_adr_i == cle_pkg::ADR_ACK_MALFORMED && sel_ok_w) ?
            32'(link_val_w[1][sel_w]) :
        (wb_adr_i == cle_pkg::ADR_HB_PARTIAL && sel_ok_w) ?
            32'(link_val_w[2][sel_w]) :
        (wb_adr_i == cle_pkg::ADR_HB_LATE && sel_ok_w) ?
            32'(link_val_w[3][sel_w]) :
        (wb_adr_i == cle_pkg::ADR_LOST_PKT) ? 32'(lost_val_w) :
        (wb_adr_i == cle_pkg::ADR_REORDER_OVR) ? 32'(ovr_val_w) :
        hit_stat_w ? 32'(irq_status_reg) :
        hit_mask_w ? 32'(irq_mask_reg) :
        (wb_adr_i == cle_pkg::ADR_LINK_STATUS) ? 32'(hb_late_reg) :
        32'h0000_0000;

    // Holding off while ack or err is out keeps a request still driven
    // in the answer cycle from being taken twice
    // Answer one cycle after the request; unmapped gets err
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_ack_reg <= 1'b0;
            wb_err_reg <= 1'b0;
            wb_dat_reg <= 32'h0000_0000;
        end else begin
            wb_ack_reg <= wb_req_w & hit_any_w;
            wb_err_reg <= wb_req_w & ~hit_any_w;
            if (wb_req_w && !wb_we_i) begin
                wb_dat_reg <= rd_data_w;
            end
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_err_o = wb_err_reg;
    assign wb_dat_o = wb_dat_reg;

    // Control register, low byte lane only
    // Upper byte lanes carry no fields, so their strobes go unused
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hb_en_reg <= cle_pkg::CTRL_HB_EN_RST;
            link_index_select <= cle_pkg::CTRL_SEL_RST;
        end else if (wb_wr_w && hit_ctrl_w && wb_sel_i[0]) begin
            hb_en_reg <= wb_dat_i[cle_pkg::CTRL_HB_EN_BIT];
            link_index_select <=
                wb_dat_i[cle_pkg::CTRL_SEL_LSB +: cle_pkg::SEL_W];
        end
    end

    // Event collection over all links
    // Software reads the per-link counters to find the link
    logic [cle_pkg::EV_N-1:0] ev_w;
    logic [cle_pkg::EV_N-1:0] w1c_w;
    assign ev_w[cle_pkg::EV_TAG] = |tag_ev_w;
    assign ev_w[cle_pkg::EV_MALF] = |malf_ev_w;
    assign ev_w[cle_pkg::EV_HB_PART] = |hbp_ev_w;
    assign ev_w[cle_pkg::EV_HB_LATE] = |late_ev_w;
    assign ev_w[cle_pkg::EV_LOST] = lost_ev_w;
    assign ev_w[cle_pkg::EV_OVR] = pbuf_overflow_i;

    // Write-one-to-clear; a new event in the same cycle wins
    assign w1c_w = (wb_wr_w && hit_stat_w && wb_sel_i[0]) ?
                   wb_dat_i[cle_pkg::EV_N-1:0] : '0;
    assign irq_status_next = (irq_status_reg & ~w1c_w) | ev_w;

    // Sticky status and mask
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_status_reg <= '0;
            irq_mask_reg <= cle_pkg::IRQ_MASK_RST;
        end else begin
            irq_status_reg <= irq_status_next;
            if (wb_wr_w && hit_mask_w && wb_sel_i[0]) begin
                irq_mask_reg <= wb_dat_i[cle_pkg::EV_N-1:0];
            end
        end
    end

    // Level interrupt while any enabled event is pending
    // Mask acts at once; events still collect while masked
    assign irq_o = |(irq_status_reg & irq_mask_reg);
endmodule

/* File: verification/cle_link_errors_monitor.sv */
// Bus and interrupt checker for the link error counter block
`timescale 1ns/10ps
module cle_link_errors_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cle_pkg::WB_ADR_W-1:0] wb_adr_i,
    // Bus reply and interrupt
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic irq_o
);
    // New request the slave must take
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // Read of a 13-bit per-link counter
    wire rd_viol = !wb_we_i && wb_adr_i >= 8'h04 && wb_adr_i <= 8'h10;
    // Read of a 12-bit stream counter
    wire rd_strm = !wb_we_i && (wb_adr_i == 8'h14 || wb_adr_i == 8'h18);
    // Single clock domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_answer;
        take |=> wb_ack_o ^ wb_err_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no single reply one cycle after request");
    property p_quiet;
        !take |=> !wb_ack_o && !wb_err_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("reply without a fresh request");
    property p_unmapped;
        take && wb_adr_i > 8'h24 |=> wb_err_o && (wb_we_i || wb_dat_o == 0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_mapped;
        take && wb_adr_i <= 8'h24 && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access not acknowledged");
    property p_viol_w;
        wb_ack_o && rd_viol |-> wb_dat_o[31:13] == 19'h0;
    endproperty
    a_viol_w: assert property (p_viol_w)
        else $error("violation counter wider than 13 bits");
    property p_strm_w;
        wb_ack_o && rd_strm |-> wb_dat_o[31:12] == 20'h0;
    endproperty
    a_strm_w: assert property (p_strm_w)
        else $error("stream counter above 4095");
    property p_hold;
        !wb_ack_o && !wb_err_o && !$past(reset_i) |-> $stable(wb_dat_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without a reply");
    property p_rst;
        $fell(reset_i) |-> !wb_ack_o && !wb_err_o && !irq_o && wb_dat_o == 0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not clear after reset");
endmodule
bind cle_link_errors cle_link_errors_monitor u_cle_link_errors_monitor (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .irq_o(irq_o));

/* File: verification/cle_camera_model.sv */
// Camera side model: control acks, heartbeats, stream tags, overruns
`timescale 1ns/10ps
module cle_camera_model #(
    parameter int LINKS = 4,
    parameter int TAG_W = 8,
    parameter int PERIOD = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control link
    output logic [LINKS-1:0] req_sent_o,
    output logic [LINKS*TAG_W-1:0] req_tag_o,
    output logic [LINKS-1:0] ack_valid_o,
    output logic [LINKS-1:0] ack_eop_o,
    output logic [LINKS*TAG_W-1:0] ack_tag_o,
    // Heartbeats
    output logic [LINKS-1:0] hb_valid_o,
    output logic [LINKS-1:0] hb_eop_o,
    // Stream and reorder buffer
    output logic pkt_valid_o,
    output logic [TAG_W-1:0] pkt_tag_o,
    output logic ovr_o
);
    logic [LINKS-1:0] hb_stop = '0; // Links holding heartbeats back
    logic [LINKS-1:0] hb_bad = '0; // Next heartbeat goes out cut short
    int hb_cnt = 0; // Shared period count
    // Quiet lines at time zero
    initial begin
        {req_sent_o, req_tag_o, ack_valid_o, ack_eop_o, ack_tag_o} = '0;
        {hb_valid_o, hb_eop_o, pkt_valid_o, pkt_tag_o, ovr_o} = '0;
    end
    // Heartbeat well inside the limit; eop toggles while idle
    always @(posedge clk_i) begin
        hb_valid_o <= '0;
        hb_eop_o <= ~hb_eop_o;
        hb_cnt <= (reset_i || hb_cnt == PERIOD - 1) ? 0 : hb_cnt + 1;
        if (!reset_i && hb_cnt == PERIOD - 1) begin
            hb_valid_o <= ~hb_stop;
            hb_eop_o <= ~hb_bad;
            hb_bad <= '0;
        end
    end
    // Flags change on the falling edge, clear of the period logic
    task hb_set(input int l, input logic stop, bad);
        @(negedge clk_i);
        hb_stop[l] = stop;
        hb_bad[l] = bad;
    endtask
    // Request, then an ack held n cycles: n acks
    task ctrl(input int l, input logic [TAG_W-1:0] rt, at,
              input logic e, input int n);
        @(posedge clk_i);
        req_sent_o[l] <= 1'b1;
        req_tag_o[l*TAG_W +: TAG_W] <= rt;
        @(posedge clk_i);
        req_sent_o[l] <= 1'b0;
        req_tag_o[l*TAG_W +: TAG_W] <= ~rt;
        ack_valid_o[l] <= 1'b1;
        ack_eop_o[l] <= e;
        ack_tag_o[l*TAG_W +: TAG_W] <= at;
        repeat (n) @(posedge clk_i);
        ack_valid_o[l] <= 1'b0;
        ack_eop_o[l] <= ~e;
        ack_tag_o[l*TAG_W +: TAG_W] <= ~at;
    endtask
    // n stream packets, tags stepping by s
    task stream(input logic [TAG_W-1:0] t, input int n, s);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            pkt_valid_o <= 1'b1;
            pkt_tag_o <= t + TAG_W'(i * s);
        end
        @(posedge clk_i);
        pkt_valid_o <= 1'b0;
        pkt_tag_o <= ~pkt_tag_o;
    endtask
    // n back-to-back buffer overruns
    task overrun(input int n);
        @(posedge clk_i);
        ovr_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        ovr_o <= 1'b0;
    endtask
endmodule

/* File: verification/test_cle_link_errors.sv */
// Self-checking bench for the link error counter block
`timescale 1ns/10ps
module test_cle_link_errors;
    localparam int T = 50; // Shortened heartbeat limit
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    // Bus master side
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack, err, irq;
    // Camera side
    wire [3:0] rs, av, ae, hv, he;
    wire [31:0] rt, at;
    wire pv, ov;
    wire [7:0] pt;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 32'hD313;
    logic [33:0] expq [$]; // Check flag, err flag, read data
    logic [7:0] r8;
    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    cle_link_errors #(.HB_TIMEOUT_CYCLES(T)) u_cle_link_errors (
        .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .req_sent_i(rs), .req_tag_i(rt), .ack_valid_i(av), .ack_eop_i(ae),
        .ack_tag_i(at), .hb_valid_i(hv), .hb_eop_i(he),
        .stream_pkt_valid_i(pv), .stream_pkt_tag_i(pt),
        .pbuf_overflow_i(ov), .irq_o(irq));
    cle_camera_model u_cle_camera_model (
        .clk_i(clk_i), .reset_i(reset_i), .req_sent_o(rs), .req_tag_o(rt),
        .ack_valid_o(av), .ack_eop_o(ae), .ack_tag_o(at), .hb_valid_o(hv),
        .hb_eop_o(he), .pkt_valid_o(pv), .pkt_tag_o(pt), .ovr_o(ov));
    // Verdict and end of run
    task end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One classic cycle; the expected reply is noted first
    task bus(input logic w, input logic [7:0] a,
             input logic [31:0] d, input logic e);
        int i;
        expq.push_back({!w, e, d});
        @(posedge clk_i);
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        cyc <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            $display("MISMATCH %0t no bus reply", $time);
            end_sim();
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 1'b0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    // Reply against the oldest note
    task cmp_reply(input logic [33:0] q);
        n_compared++;
        if (err !== q[32] || (q[33] && rdat !== q[31:0])) begin
            n_mismatch++;
            $display("MISMATCH %0t at %h got %h", $time, adr, rdat);
        end
    endtask
    // Interrupt level once settled
    task cmp_irq(input logic e);
        @(posedge clk_i);
        n_compared++;
        if (irq !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t irq level", $time);
        end
    endtask
    // Watcher: every reply takes one note
    always @(posedge clk_i) begin
        if (ack === 1'b1 || err === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH %0t stray reply", $time);
            end else begin
                cmp_reply(expq.pop_front());
            end
        end
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(8'h00, 32'h1);
        for (int k = 1; k < 10; k++) rd(8'(4 * k), 32'h0);
        bus(1'b0, 8'h28, 32'h0, 1'b1);
        bus(1'b1, 8'h30, 32'hFF, 1'b1);
        $display("done: reset and map");
        wr(8'h00, 32'h11);
        r8 = 8'($random(seed));
        u_cle_camera_model.ctrl(1, r8, r8, 1'b1, 1);
        u_cle_camera_model.ctrl(1, r8, r8 + 8'h01, 1'b1, 1);
        u_cle_camera_model.ctrl(1, r8, ~r8, 1'b0, 1);
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h1);
        wr(8'h04, 32'hFFF);
        rd(8'h04, 32'h1);
        u_cle_camera_model.hb_set(1, 1'b0, 1'b1);
        repeat (45) @(posedge clk_i);
        rd(8'h0C, 32'h1);
        u_cle_camera_model.hb_set(1, 1'b1, 1'b0);
        repeat (T + 30) @(posedge clk_i);
        rd(8'h24, 32'h2);
        rd(8'h10, 32'h1);
        // Monitor off: a silent link is neither counted nor flagged
        wr(8'h00, 32'h10);
        repeat (T + 30) @(posedge clk_i);
        rd(8'h10, 32'h1);
        rd(8'h24, 32'h0);
        u_cle_camera_model.hb_set(1, 1'b0, 1'b0);
        $display("done: control and heartbeat");
        wr(8'h00, 32'h31);
        u_cle_camera_model.ctrl(3, r8, r8, 1'b0, 4096);
        rd(8'h08, 32'h1000);
        u_cle_camera_model.ctrl(3, r8, r8, 1'b0, 1);
        rd(8'h08, 32'h1001);
        rd(8'h04, 32'h0);
        $display("done: overflow");
        r8 = 8'($random(seed));
        u_cle_camera_model.stream(r8, 2, 1);
        u_cle_camera_model.stream(r8 + 8'h04, 1, 0);
        rd(8'h14, 32'h2);
        u_cle_camera_model.stream(r8 + 8'h84, 40, 128);
        rd(8'h14, 32'hFFF);
        u_cle_camera_model.overrun(3);
        rd(8'h18, 32'h3);
        u_cle_camera_model.overrun(4100);
        rd(8'h18, 32'hFFF);
        $display("done: stream");
        rd(8'h1C, 32'h3F);
        cmp_irq(1'b0);
        wr(8'h20, 32'h20);
        cmp_irq(1'b1);
        wr(8'h1C, 32'h20);
        cmp_irq(1'b0);
        rd(8'h1C, 32'h1F);
        repeat (2) @(posedge clk_i);
        $display("done: interrupt");
        // Reset in mid-run clears counts and the overflow flag
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(8'h14, 32'h0);
        wr(8'h00, 32'h31);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h31);
        $display("done: second reset");
        end_sim();
    end
endmodule
